// [logic/pec_comp.sv]
// Positioner error compensation core: backlash, hysteresis, scale and table
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module pec_comp
  import pec_pkg::*;
(
  // Clock and reset
  input  wire logic                 sys_clk_in,
  input  wire logic                 rst_in,
  // Register port
  input  wire logic [AW-1:0]        reg_addr_in,
  input  wire logic [DW-1:0]        reg_wdata_in,
  input  wire logic                 reg_wr_in,
  input  wire logic                 reg_rd_in,
  output logic [DW-1:0]             reg_rdata_out,
  // Motion profiler
  input  wire logic signed [DW-1:0] prof_setpoint_in,
  input  wire logic                 prof_done_in,
  output logic signed [DW-1:0]      prof_goal_out,
  output logic                      prof_start_out,
  // Encoder feedback
  input  wire logic signed [DW-1:0] enc_count_in,
  input  wire logic                 home_found_in,
  // Status
  output logic                      move_busy_out
);
  typedef enum logic [1:0] {PEC_IDLE, PEC_OVER, PEC_MOVE} pec_state_e;

  // ==========================================================
  // Configuration state
  logic [2:0]           ctrl;
  logic signed [DW-1:0] backlash_amount;
  logic signed [DW-1:0] hyst_amount;
  logic signed [DW-1:0] scale_correction_ppm;
  logic signed [DW-1:0] home_reference_value;
  logic                 bl_en;
  logic [TBL_AW-1:0]    tbl_addr;
  logic [2:0]           next_ctrl;
  logic signed [DW-1:0] next_bl_amt;
  logic signed [DW-1:0] next_hyst;
  logic signed [DW-1:0] next_ppm;
  logic signed [DW-1:0] next_home;
  logic                 next_bl_en;
  logic [TBL_AW-1:0]    next_taddr;
  logic                 wr_hit;
  logic                 bl_on;

  assign wr_hit = reg_wr_in;

  // Configuration next values
  always_comb begin
    next_ctrl   = ctrl;
    next_bl_amt = backlash_amount;
    next_hyst   = hyst_amount;
    next_ppm    = scale_correction_ppm;
    next_home   = home_reference_value;
    next_bl_en  = bl_en;
    next_taddr  = tbl_addr;
    if (wr_hit) begin
      unique case (reg_addr_in)
        ADDR_CTRL:  next_ctrl   = reg_wdata_in[2:0];
        ADDR_BL:    next_bl_amt = $signed(reg_wdata_in);
        ADDR_HYST:  next_hyst   = $signed(reg_wdata_in);
        ADDR_PPM:   next_ppm    = $signed(reg_wdata_in);
        ADDR_HOME:  next_home   = $signed(reg_wdata_in);
        ADDR_TADDR: next_taddr  = reg_wdata_in[TBL_AW-1:0];
        ADDR_CMD: begin
          if (reg_wdata_in[CMD_BL_OFF]) begin
            next_bl_en = 1'b0;
          end else if (reg_wdata_in[CMD_BL_ON]) begin
            next_bl_en = 1'b1;
          end
        end
        default: ;
      endcase
    end
  end

  // Configuration registers; backlash on after reset
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl                 <= CTRL_RST;
      backlash_amount      <= ZERO_RST;
      hyst_amount          <= ZERO_RST;
      scale_correction_ppm <= ZERO_RST;
      home_reference_value <= ZERO_RST;
      bl_en                <= BL_EN_RST;
      tbl_addr             <= '0;
    end else begin
      ctrl                 <= next_ctrl;
      backlash_amount      <= next_bl_amt;
      hyst_amount          <= next_hyst;
      scale_correction_ppm <= next_ppm;
      home_reference_value <= next_home;
      bl_en                <= next_bl_en;
      tbl_addr             <= next_taddr;
    end
  end

  // no backlash when homing at present spot
  // backlash amount must be above zero
  assign bl_on = bl_en && (backlash_amount > 0) &&
                 (ctrl[CTRL_HOME_LO +: 2] != HOME_AT_PRESENT);

  // ==========================================================
  // Move sequencing
  pec_state_e           state;
  pec_state_e           next_state;
  logic signed [DW-1:0] move_goal;
  logic signed [DW-1:0] bl_off;
  logic                 last_neg;
  logic signed [DW-1:0] next_goal;
  logic signed [DW-1:0] next_off;
  logic                 next_neg;
  logic signed [DW-1:0] next_pgoal;
  logic                 next_start;
  logic                 goal_wr;
  logic                 dir_neg;
  logic                 done_ok;

  assign goal_wr = reg_wr_in && (reg_addr_in == ADDR_GOAL) && (state == PEC_IDLE);
  assign dir_neg = $signed(reg_wdata_in) < move_goal;
  assign done_ok = prof_done_in && !prof_start_out;

  // Sequencer next values
  always_comb begin
    next_state = state;
    next_goal  = move_goal;
    next_off   = bl_off;
    next_neg   = last_neg;
    next_pgoal = prof_goal_out;
    next_start = 1'b0;
    unique case (state)
      PEC_IDLE: begin
        if (goal_wr) begin
          next_goal = $signed(reg_wdata_in);
          // reversal is new sign against stored sign
          next_neg  = dir_neg;
          // reversal shifts internal goal by backlash
          if (!bl_on) begin
            next_off = ZERO_RST;
          end else if (dir_neg != last_neg) begin
            next_off = dir_neg ? bl_off - backlash_amount : bl_off + backlash_amount;
          end
          next_pgoal = next_goal + next_off;
          next_start = 1'b1;
          next_state = PEC_MOVE;
          if ((hyst_amount != 0) && !dir_neg) begin
            next_pgoal = next_goal + next_off + hyst_amount;
            next_state = PEC_OVER;
          end
        end
      end
      PEC_OVER: begin
        // return move of the hysteresis amount
        if (done_ok) begin
          next_pgoal = move_goal + bl_off;
          next_start = 1'b1;
          next_state = PEC_MOVE;
        end
      end
      PEC_MOVE: begin
        if (done_ok) begin
          next_state = PEC_IDLE;
        end
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state          <= PEC_IDLE;
      move_goal      <= ZERO_RST;
      bl_off         <= ZERO_RST;
      last_neg       <= 1'b0;
      prof_goal_out  <= ZERO_RST;
      prof_start_out <= 1'b0;
      move_busy_out  <= 1'b0;
    end else begin
      state          <= next_state;
      move_goal      <= next_goal;
      bl_off         <= next_off;
      last_neg       <= next_neg;
      prof_goal_out  <= next_pgoal;
      prof_start_out <= next_start;
      move_busy_out  <= (next_state != PEC_IDLE);
    end
  end

  // ==========================================================
  // Feedback path: home capture, scale, table, measured location
  logic signed [DW-1:0] enc_home;
  logic                 homed;
  logic signed [DW-1:0] next_enc_home;
  logic                 next_homed;
  logic signed [DW-1:0] raw_feedback_reading;
  logic signed [DW-1:0] scaled;
  logic signed [DW-1:0] scaled_d;
  logic signed [DW-1:0] measured_location;
  logic signed [DW-1:0] next_meas;
  logic signed [DW-1:0] map_term;
  pec_tbl_if            tbl ();

  // home found reloads raw reading with home reference
  always_comb begin
    next_enc_home = enc_home;
    next_homed    = homed;
    if (home_found_in) begin
      next_enc_home = enc_count_in;
      next_homed    = 1'b1;
    end
    raw_feedback_reading = enc_count_in - enc_home + home_reference_value;
  end

  // Home capture registers
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      enc_home <= ZERO_RST;
      homed    <= 1'b0;
    end else begin
      enc_home <= next_enc_home;
      homed    <= next_homed;
    end
  end

  // scale stage feeds the table stage
  pec_scale u_scale (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .raw_in     (raw_feedback_reading),
    .home_in    (home_reference_value),
    .ppm_in     (scale_correction_ppm),
    .corr_out   (scaled)
  );

  // table indexed by scaled location, loaded by software
  assign tbl.rd_addr = scaled[MAP_LSB +: TBL_AW];
  assign tbl.wr_en   = reg_wr_in && (reg_addr_in == ADDR_TDATA);
  assign tbl.wr_addr = tbl_addr;
  assign tbl.wr_data = reg_wdata_in;

  pec_tbl_mem u_tbl (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .tbl        (tbl)
  );

  // measured after all corrections; backlash hidden
  always_comb begin
    map_term  = ctrl[CTRL_MAP_EN] ? $signed(tbl.rd_data) : ZERO_RST;
    next_meas = scaled_d + map_term - bl_off;
  end

  // Measured pipeline registers
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      scaled_d          <= ZERO_RST;
      measured_location <= ZERO_RST;
    end else begin
      scaled_d          <= scaled;
      measured_location <= next_meas;
    end
  end

  // ==========================================================
  // Register readback
  logic [DW-1:0]        next_rdata;
  logic signed [DW-1:0] commanded_location;

  assign commanded_location = prof_setpoint_in - bl_off;

  // Read mux, unmapped and write-only addresses read zero
  always_comb begin
    next_rdata = ZERO_RST;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        ADDR_CTRL:   next_rdata = {29'h0000_0000, ctrl};
        ADDR_BL:     next_rdata = backlash_amount;
        ADDR_HYST:   next_rdata = hyst_amount;
        ADDR_PPM:    next_rdata = scale_correction_ppm;
        ADDR_HOME:   next_rdata = home_reference_value;
        ADDR_GOAL:   next_rdata = move_goal;
        ADDR_STAT:   next_rdata = {28'h000_0000, homed, last_neg,
                                   (state != PEC_IDLE), bl_on};
        ADDR_MEAS:   next_rdata = measured_location;
        ADDR_CMDLOC: next_rdata = commanded_location;
        ADDR_TADDR:  next_rdata = {28'h000_0000, tbl_addr};
        default:     next_rdata = ZERO_RST;
      endcase
    end
  end

  // Read data register
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= ZERO_RST;
    end else begin
      reg_rdata_out <= next_rdata;
    end
  end

  // ==========================================================
  // Checks
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  a_goal_internal : assert property (
    (goal_wr && (hyst_amount == 0)) |=> prof_start_out && (prof_goal_out == move_goal + bl_off))
    else $error("internal goal not issued");

  a_bl_reversal : assert property (
    (goal_wr && bl_on && (dir_neg != last_neg))
      |=> (bl_off - $past(bl_off)) == (last_neg ? -backlash_amount : backlash_amount))
    else $error("backlash not applied on reversal");

  a_bl_gate : assert property (
    (goal_wr && !bl_on) |=> bl_off == 0) else $error("offset kept with backlash off");

  a_sign_store : assert property (
    goal_wr |=> last_neg == $past(dir_neg)) else $error("direction sign not stored");

  a_hyst_seq : assert property (
    (goal_wr && (hyst_amount != 0) && !dir_neg)
      |=> (state == PEC_OVER) && (prof_goal_out == move_goal + bl_off + hyst_amount))
    else $error("hysteresis overshoot missing");

  a_bl_disable : assert property (
    (reg_wr_in && (reg_addr_in == ADDR_CMD) && reg_wdata_in[CMD_BL_OFF]) |=> !bl_en)
    else $error("backlash disable ignored");

  a_home_load : assert property (
    home_found_in |=> homed && (enc_home == $past(enc_count_in)))
    else $error("home reference not loaded");

  a_cmd_hidden : assert property (
    (reg_rd_in && (reg_addr_in == ADDR_CMDLOC))
      |=> reg_rdata_out == $past(prof_setpoint_in) - $past(bl_off))
    else $error("commanded location shows offset");

  // measured location two stages after scale
  a_meas_chain : assert property (
    !ctrl[CTRL_MAP_EN] |=> measured_location == $past(scaled, 2) - $past(bl_off))
    else $error("measured location stale");
endmodule

// [logic/pec_pkg.sv]
// Constants shared by the positioner error compensation block
package pec_pkg;
  // ==========================================================
  // Widths
  localparam int DW        = 32;
  localparam int AW        = 8;
  localparam int TBL_AW    = 4;
  localparam int MAP_LSB   = 12;
  // ==========================================================
  // Register byte addresses
  localparam logic [AW-1:0] ADDR_CTRL   = 8'h00;
  localparam logic [AW-1:0] ADDR_CMD    = 8'h04;
  localparam logic [AW-1:0] ADDR_BL     = 8'h08;
  localparam logic [AW-1:0] ADDR_HYST   = 8'h0C;
  localparam logic [AW-1:0] ADDR_PPM    = 8'h10;
  localparam logic [AW-1:0] ADDR_HOME   = 8'h14;
  localparam logic [AW-1:0] ADDR_GOAL   = 8'h18;
  localparam logic [AW-1:0] ADDR_STAT   = 8'h1C;
  localparam logic [AW-1:0] ADDR_MEAS   = 8'h20;
  localparam logic [AW-1:0] ADDR_CMDLOC = 8'h24;
  localparam logic [AW-1:0] ADDR_TADDR  = 8'h28;
  localparam logic [AW-1:0] ADDR_TDATA  = 8'h2C;
  // ==========================================================
  // Field positions and codes
  localparam int CTRL_MAP_EN  = 0;
  localparam int CTRL_HOME_LO = 1;
  localparam int CMD_BL_OFF   = 0;
  localparam int CMD_BL_ON    = 1;
  localparam int ST_BL_ACT    = 0;
  localparam int ST_BUSY      = 1;
  localparam int ST_DIR_NEG   = 2;
  localparam int ST_HOMED     = 3;
  localparam logic [1:0] HOME_AT_PRESENT = 2'h0;
  // ==========================================================
  // Reset values and scale divisor
  localparam logic [2:0]    CTRL_RST   = 3'h2;
  localparam logic          BL_EN_RST  = 1'b1;
  localparam logic [DW-1:0] ZERO_RST   = 32'h0000_0000;
  localparam logic signed [63:0] PPM_DIV = 64'sh0000_0000_000F_4240;
endpackage

// [logic/pec_tbl_if.sv]
// Port bundle between the compensation core and its table memory
`timescale 1ns/1ps
interface pec_tbl_if;
  import pec_pkg::*;
  logic              wr_en;
  logic [TBL_AW-1:0] wr_addr;
  logic [DW-1:0]     wr_data;
  logic [TBL_AW-1:0] rd_addr;
  logic [DW-1:0]     rd_data;
  modport owner (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
  modport mem   (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface

// [logic/pec_tbl_mem.sv]
// Nonlinear correction table with registered read data
`timescale 1ns/1ps
module pec_tbl_mem
  import pec_pkg::*;
(
  // Clock and reset
  input  wire logic sys_clk_in,
  input  wire logic rst_in,
  // Table port
  pec_tbl_if.mem    tbl
);
  logic [DW-1:0] mem_q [2**TBL_AW];
  logic [DW-1:0] next_rd;

  // Read mux, written value visible next read
  always_comb begin
    next_rd = mem_q[tbl.rd_addr];
  end

  // Storage write
  always_ff @(posedge sys_clk_in) begin
    if (tbl.wr_en) begin
      mem_q[tbl.wr_addr] <= tbl.wr_data;
    end
  end

  // Read data register
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      tbl.rd_data <= ZERO_RST;
    end else begin
      tbl.rd_data <= next_rd;
    end
  end

  a_table_read : assert property (@(posedge sys_clk_in) disable iff (rst_in)
    tbl.wr_en ##1 (tbl.rd_addr == $past(tbl.wr_addr))
      |=> tbl.rd_data == $past(tbl.wr_data, 2)) else $error("table read data wrong");
endmodule

// [logic/pec_scale.sv]
// Linear scale correction around the home reference
`timescale 1ns/1ps
module pec_scale
  import pec_pkg::*;
(
  // Clock and reset
  input  wire logic                 sys_clk_in,
  input  wire logic                 rst_in,
  // Operands
  input  wire logic signed [DW-1:0] raw_in,
  input  wire logic signed [DW-1:0] home_in,
  input  wire logic signed [DW-1:0] ppm_in,
  // Result
  output logic signed [DW-1:0]      corr_out
);
  logic signed [DW-1:0] diff;
  logic signed [63:0]   prod;
  logic signed [63:0]   adj;
  logic signed [DW-1:0] next_corr;

  // home plus scaled distance from home
  always_comb begin
    diff      = raw_in - home_in;
    // ppm setting divided by one million
    prod      = 64'(diff) * 64'(ppm_in);
    adj       = prod / PPM_DIV;
    next_corr = home_in + diff + adj[DW-1:0];
  end

  // Result register
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      corr_out <= ZERO_RST;
    end else begin
      corr_out <= next_corr;
    end
  end

  a_scale_zero : assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (ppm_in == 0) |=> corr_out == $past(raw_in)) else $error("zero ppm altered reading");
endmodule

// [tb/pec_prof_model.sv]
// Behavioural motion profiler that answers each start with a done pulse
`timescale 1ns/1ps
module pec_prof_model
  import pec_pkg::*;
(
  // Clock and reset
  input  wire logic                 sys_clk_in,
  input  wire logic                 rst_in,
  // Pace select
  input  wire logic                 slow_in,
  // Profiler side
  input  wire logic signed [DW-1:0] goal_in,
  input  wire logic                 start_in,
  output logic signed [DW-1:0]      setpoint_out,
  output logic                      done_out
);
  int cnt;
  // ==========================================================
  // Move timing
  // Count down after each start, then report done with setpoint at the goal
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt <= 0;
      setpoint_out <= '0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (start_in) begin
        cnt <= slow_in ? 9 : 2;  // Done never lands in the start cycle
      end else if (cnt == 1) begin
        done_out <= 1'b1;
        setpoint_out <= goal_in;
        cnt <= 0;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule

// [tb/pec_comp_test.sv]
// Self-checking bench for the positioner error compensation core
`timescale 1ns/1ps
module pec_comp_test
  import pec_pkg::*;
;
  logic                 sys_clk_in = 1'b0;
  logic                 rst_in     = 1'b1;
  logic [AW-1:0]        reg_addr   = '0;
  logic [DW-1:0]        reg_wdata  = '0;
  logic                 reg_wr     = 1'b0;
  logic                 reg_rd     = 1'b0;
  logic [DW-1:0]        reg_rdata;
  logic signed [DW-1:0] setpoint;
  logic                 done;
  logic signed [DW-1:0] goal;
  logic                 start;
  logic signed [DW-1:0] enc        = '0;
  logic                 home_found = 1'b0;
  logic                 busy;
  logic                 slow       = 1'b0;
  int                   errors     = 0;
  int                   compares   = 0;
  logic [AW-1:0]        ra [11] = '{8'h00, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h20,
                                    8'h24, 8'h04, 8'h2C, 8'h30};
  logic [DW-1:0]        rv [11] = '{32'h2, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0};
  // ==========================================================
  // Clock, design and partner
  always #5 sys_clk_in = ~sys_clk_in;
  pec_comp DUT (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_rdata_out(reg_rdata), .prof_setpoint_in(setpoint), .prof_done_in(done),
    .prof_goal_out(goal), .prof_start_out(start), .enc_count_in(enc),
    .home_found_in(home_found), .move_busy_out(busy));
  pec_prof_model prof (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .slow_in(slow),
    .goal_in(goal), .start_in(start), .setpoint_out(setpoint), .done_out(done));
  // ==========================================================
  // Checking and bus tasks
  task automatic chk(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] v);
    @(posedge sys_clk_in);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk_in);
    reg_wr <= 1'b0;
  endtask
  task automatic rdchk(input logic [AW-1:0] a, input logic [DW-1:0] mask,
                       input logic [DW-1:0] exp);
    @(posedge sys_clk_in);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk_in);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata & mask, exp);
  endtask
  // Called at a clock edge: finds the next start pulse while it stands, checks its goal
  task automatic see_start(input logic [DW-1:0] e);
    int k;
    k = 0;
    #1;
    while (start !== 1'b1 && k < 30) begin
      @(posedge sys_clk_in);
      #1;
      k++;
    end
    chk(start, 1'b1);
    chk(goal, e);
    chk(busy, 1'b1);
    @(posedge sys_clk_in);
  endtask
  // Waits for the sequence to return to idle
  task automatic wait_idle();
    int k;
    k = 0;
    #1;
    while (busy !== 1'b0 && k < 30) begin
      @(posedge sys_clk_in);
      #1;
      k++;
    end
    chk(busy, 1'b0);
  endtask
  task automatic mv(input logic [DW-1:0] g, input logic [DW-1:0] e0);
    wr(ADDR_GOAL, g);
    see_start(e0);
    wait_idle();
  endtask
  // Plain scaled reading, then the same with one table entry added
  task automatic meas(input logic [DW-1:0] e, input logic [DW-1:0] idx,
                      input logic [DW-1:0] tv, input logic [DW-1:0] exp);
    wr(ADDR_CTRL, 32'h2);
    enc <= e;
    repeat (4) @(posedge sys_clk_in);
    rdchk(ADDR_MEAS, 32'hFFFF_FFFF, exp);
    wr(ADDR_TADDR, idx);
    wr(ADDR_TDATA, tv);
    wr(ADDR_CTRL, 32'h3);
    repeat (4) @(posedge sys_clk_in);
    rdchk(ADDR_MEAS, 32'hFFFF_FFFF, exp + tv);
  endtask
  // ==========================================================
  // Watchdog cuts a hang short
  initial begin
    #100us;
    errors++;
    close_out();
  end
  // ==========================================================
  // Main sequence
  initial begin
    repeat (6) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    wr(8'h30, 32'h55);
    for (int i = 0; i < 11; i++) rdchk(ra[i], 32'hFFFF_FFFF, rv[i]);
    rdchk(ADDR_STAT, 32'h2, 32'h0);
    wr(ADDR_BL, 32'h5);
    rdchk(ADDR_STAT, 32'h1, 32'h1);
    mv(32'd100, 32'd100);
    mv(32'd50, 32'd45);
    rdchk(ADDR_GOAL, 32'hFFFF_FFFF, 32'd50);
    rdchk(ADDR_CMDLOC, 32'hFFFF_FFFF, 32'd50);
    rdchk(ADDR_MEAS, 32'hFFFF_FFFF, 32'd5);
    rdchk(ADDR_STAT, 32'h4, 32'h4);
    mv(32'd80, 32'd80);
    mv(32'd90, 32'd90);
    wr(ADDR_CMD, 32'h1);
    rdchk(ADDR_STAT, 32'h1, 32'h0);
    mv(32'd20, 32'd20);
    wr(ADDR_CMD, 32'h2);
    mv(32'd30, 32'd35);
    wr(ADDR_CTRL, 32'h0);
    mv(32'd10, 32'd10);
    wr(ADDR_CTRL, 32'h2);
    wr(ADDR_BL, 32'hFFFF_FFFD);
    mv(32'd40, 32'd40);
    // Backlash cleared before hysteresis is set, so only one is nonzero
    wr(ADDR_BL, 32'h0);
    wr(ADDR_HYST, 32'h7);
    slow <= 1'b1;
    wr(ADDR_GOAL, 32'd60);
    see_start(32'd67);
    wr(ADDR_GOAL, 32'd999);
    see_start(32'd60);
    wait_idle();
    rdchk(ADDR_GOAL, 32'hFFFF_FFFF, 32'd60);
    mv(32'd50, 32'd50);
    // A later positive move gets the overshoot again
    wr(ADDR_GOAL, 32'd55);
    see_start(32'd62);
    see_start(32'd55);
    wait_idle();
    slow <= 1'b0;
    wr(ADDR_HYST, 32'h0);
    wr(ADDR_HOME, 32'd1000);
    wr(ADDR_PPM, 32'd2000);
    enc <= 32'd500;
    @(posedge sys_clk_in);
    home_found <= 1'b1;
    @(posedge sys_clk_in);
    home_found <= 1'b0;
    rdchk(ADDR_STAT, 32'h8, 32'h8);
    // Table used only with backlash at zero
    meas(32'd100500, 32'h8, 32'h11, 32'd101200);
    meas(-32'sd11845, 32'hD, 32'h3, -32'sd11369);
    close_out();
  end
endmodule
